// file: core/obr_cell.sv
// One storage bit with async zero and capture enable
module obr_cell #(
	parameter bit INVERT = 1'b0
) (
	input  wire logic clk_in,
	input  wire logic resetn_in,
	input  wire logic zero_n_in,
	input  wire logic capture_n_in,
	input  wire logic d_in,
	output logic      q_out
);
	wire logic clr_n;
	wire logic d_eff;

	// Bus reset and clear both act asynchronously
	assign clr_n = resetn_in & zero_n_in;
	assign d_eff = INVERT ? ~d_in : d_in; // [R04]

	always_ff @(posedge clk_in or negedge clr_n) begin
		if (!clr_n)
			q_out <= 1'b0; // [R05]
		else if (!capture_n_in)
			q_out <= d_eff; // [R02]
		// Otherwise hold [R03]
	end
endmodule // obr_cell

// file: core/obr_pkg.sv
// Package with constants for the octet bus register
// Contract
// [R01] The block holds an eight-bit word in edge-triggered cells, one data input and one output line per bit.
// [R02] With capture enable low and clear inactive, every cell loads its input on each rising clock edge; the code also needs control bit 0 low, reset 1.
// [R03] With capture enable high, clock edges are ignored and the word holds until enabled again or cleared.
// [R04] A build parameter selects storing the input as presented or storing its complement.
// [R05] Clear low forces all stored bits to zero at once, without a clock edge and regardless of other inputs.
// [R06] Outputs float while any of the three drive enables is high and drive the word only when all are low.
// [R07] The drive enables never affect storage; capture, hold and clear work the same while floating.
// [R08] The float condition appears as a per-bit drive-enable output beside the stored word, not a tristate net.
package obr_pkg;
	localparam int                WORD_WIDTH  = 8;
	localparam logic [7:0]        WORD_RESET  = 8'h00;
	localparam bit                INVERT_DFLT = 1'b0;
	localparam int                APB_AW      = 12;
	// Register byte addresses
	localparam logic [11:0]       CTRL_ADDR   = 12'h000;
	localparam logic [11:0]       STATUS_ADDR = 12'h004;
	localparam logic [11:0]       WORD_ADDR   = 12'h008;
	// Control field positions
	localparam int                CTRL_CAPEN_BIT = 0;
	localparam int                CTRL_DRVA_BIT  = 1;
	localparam int                CTRL_DRVB_BIT  = 2;
	localparam int                CTRL_DRVC_BIT  = 3;
	localparam int                CTRL_ZERO_BIT  = 4;
	// Control reset: capture disabled, all drivers off, clear inactive
	localparam logic [4:0]        CTRL_RESET  = 5'h1f;
	// Status field positions
	localparam int                STAT_FLOAT_BIT = 0;
endpackage : obr_pkg

// file: core/obr_top.sv
// Octet bus register with three drive enables and an APB control port
module obr_top #(
	parameter int WIDTH  = obr_pkg::WORD_WIDTH,
	parameter bit INVERT = obr_pkg::INVERT_DFLT
) (
	// Clock and reset
	input  wire logic                       CLK_IN,
	input  wire logic                       RESETN_IN,
	// APB slave
	input  wire logic                       PSEL_IN,
	input  wire logic                       PENABLE_IN,
	input  wire logic                       PWRITE_IN,
	input  wire logic [obr_pkg::APB_AW-1:0] PADDR_IN,
	input  wire logic [31:0]                PWDATA_IN,
	output logic      [31:0]                PRDATA_OUT,
	output logic                            PREADY_OUT,
	output logic                            PSLVERR_OUT,
	// Pins: data in, async clear, capture and drive enables
	input  wire logic [WIDTH-1:0]           DATA_IN,
	input  wire logic                       ASYNC_ZERO_N_IN,
	input  wire logic                       CAPTURE_ENABLE_N_IN,
	input  wire logic                       DRIVE_ENABLE_A_N_IN,
	input  wire logic                       DRIVE_ENABLE_B_N_IN,
	input  wire logic                       DRIVE_ENABLE_C_N_IN,
	// Bus side
	output logic      [WIDTH-1:0]           WORD_OUT,
	output logic      [WIDTH-1:0]           WORD_OE_OUT
);
	logic [4:0]       ctrl_q;
	logic [4:0]       ctrl_d;
	wire  logic [WIDTH-1:0] word;
	wire  logic       capture_enable_n;
	wire  logic       async_zero_n;
	wire  logic       combined_float_request;
	wire  logic       wr_en;
	wire  logic       hit_ctrl;
	wire  logic       hit_status;
	wire  logic       hit_word;
	wire  logic       unmapped;
	wire  logic [31:0] rd_mux;

	// Pin and software controls combine: either side can disable capture or drive, and either side can clear
	assign capture_enable_n = CAPTURE_ENABLE_N_IN | ctrl_q[obr_pkg::CTRL_CAPEN_BIT];
	assign async_zero_n     = ASYNC_ZERO_N_IN & ctrl_q[obr_pkg::CTRL_ZERO_BIT];
	assign combined_float_request = DRIVE_ENABLE_A_N_IN | DRIVE_ENABLE_B_N_IN | DRIVE_ENABLE_C_N_IN
		| ctrl_q[obr_pkg::CTRL_DRVA_BIT] | ctrl_q[obr_pkg::CTRL_DRVB_BIT]
		| ctrl_q[obr_pkg::CTRL_DRVC_BIT]; // [R06]

	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			// Drive enables are not wired here, so storage ignores them [R07]
			obr_cell #(.INVERT(INVERT)) u_cell (
				.clk_in       (CLK_IN),
				.resetn_in    (RESETN_IN),
				.zero_n_in    (async_zero_n),
				.capture_n_in (capture_enable_n),
				.d_in         (DATA_IN[i]),
				.q_out        (word[i])
			); // [R01]
		end
	endgenerate

	assign WORD_OUT    = word;
	assign WORD_OE_OUT = {WIDTH{~combined_float_request}}; // [R08]

	// APB decode; slave always ready, unmapped access errors
	assign hit_ctrl    = PADDR_IN == obr_pkg::CTRL_ADDR;
	assign hit_status  = PADDR_IN == obr_pkg::STATUS_ADDR;
	assign hit_word    = PADDR_IN == obr_pkg::WORD_ADDR;
	assign unmapped    = ~(hit_ctrl | hit_status | hit_word);
	assign wr_en       = PSEL_IN & PENABLE_IN & PWRITE_IN & hit_ctrl;
	assign ctrl_d      = wr_en ? PWDATA_IN[4:0] : ctrl_q;
	assign rd_mux      = hit_ctrl   ? {27'h0, ctrl_q}
		: hit_status ? {31'h0, combined_float_request}
		: hit_word   ? {{(32-WIDTH){1'b0}}, word}
		: 32'h0;
	assign PREADY_OUT  = 1'b1;
	assign PSLVERR_OUT = PSEL_IN & PENABLE_IN & unmapped;

	always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN)
			ctrl_q <= obr_pkg::CTRL_RESET;
		else
			ctrl_q <= ctrl_d;
	end

	// Read data registered in setup phase so it is stable in access
	always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN)
			PRDATA_OUT <= 32'h0;
		else if (PSEL_IN & ~PENABLE_IN & ~PWRITE_IN)
			PRDATA_OUT <= rd_mux;
	end
endmodule // obr_top

// file: test/obr_monitor.sv
// Port checker for the octet bus register
module obr_monitor #(parameter int WIDTH = 8, parameter bit INVERT = 1'b0) (
	input wire logic CLK_IN, RESETN_IN, PSEL_IN, PENABLE_IN, PREADY_OUT, PSLVERR_OUT, ASYNC_ZERO_N_IN,
	input wire logic CAPTURE_ENABLE_N_IN, DRIVE_ENABLE_A_N_IN, DRIVE_ENABLE_B_N_IN, DRIVE_ENABLE_C_N_IN,
	input wire logic [WIDTH-1:0] DATA_IN, WORD_OUT, WORD_OE_OUT);
	timeunit 1ns; timeprecision 1ps;
	default clocking @(posedge CLK_IN); endclocking
	default disable iff (!RESETN_IN);
	wire fl = DRIVE_ENABLE_A_N_IN | DRIVE_ENABLE_B_N_IN | DRIVE_ENABLE_C_N_IN;
	a_hold_word: assert property ($past(CAPTURE_ENABLE_N_IN) && $past(ASYNC_ZERO_N_IN) && ASYNC_ZERO_N_IN
		|-> $stable(WORD_OUT)) else $error("word moved while capture off");
	a_load_data: assert property (ASYNC_ZERO_N_IN && $changed(WORD_OUT) |-> !$past(CAPTURE_ENABLE_N_IN)
		&& WORD_OUT == ($past(DATA_IN) ^ {WIDTH{INVERT}})) else $error("bad captured word");
	a_zero_now: assert property (!ASYNC_ZERO_N_IN |-> WORD_OUT == '0) else $error("clear not immediate");
	a_zero_held: assert property ($past(ASYNC_ZERO_N_IN) == 1'b0 |-> WORD_OUT == '0) else $error("clear lost");
	a_float_any: assert property (fl |-> WORD_OE_OUT == '0) else $error("driving while floated");
	a_oe_whole: assert property (WORD_OE_OUT == '0 || WORD_OE_OUT == '1) else $error("split enable");
	a_ready_now: assert property (PSEL_IN && PENABLE_IN |-> PREADY_OUT) else $error("ready late");
	a_err_access: assert property (PSLVERR_OUT |-> PSEL_IN && PENABLE_IN) else $error("stray error");
	c_load: cover property (!CAPTURE_ENABLE_N_IN ##1 $changed(WORD_OUT));
	c_drive: cover property (WORD_OE_OUT == '1);
	c_err: cover property (PSLVERR_OUT);
	c_clear: cover property (!ASYNC_ZERO_N_IN);
endmodule // obr_monitor
bind obr_top obr_monitor #(.WIDTH(WIDTH), .INVERT(INVERT)) mon (.*);

// file: test/obr_src.sv
// Upstream source: presents a word one cycle after it is asked
module obr_src (
	input  wire logic       clk_in,
	input  wire logic [7:0] val_in,
	output logic      [7:0] data_out = 8'h00
);
	timeunit 1ns; timeprecision 1ps;
	always @(posedge clk_in) data_out <= val_in;
endmodule // obr_src

// file: test/test_octet_bus_register_tristate.sv
// Self-checking bench for the octet bus register
module test_octet_bus_register_tristate;
	timeunit 1ns; timeprecision 1ps;
	logic CLK_IN = 0, RESETN_IN = 0, PSEL_IN = 0, PENABLE_IN = 0, PWRITE_IN = 0, PREADY_OUT, PSLVERR_OUT;
	logic ASYNC_ZERO_N_IN = 1, CAPTURE_ENABLE_N_IN = 1, DRIVE_ENABLE_A_N_IN = 1, DRIVE_ENABLE_B_N_IN = 1;
	logic DRIVE_ENABLE_C_N_IN = 1;
	logic [11:0] PADDR_IN = '0;
	logic [31:0] PWDATA_IN = '0, PRDATA_OUT;
	logic [7:0] val = '0, mw = '0, DATA_IN, WORD_OUT, WORD_OE_OUT;
	logic [15:0] exp_q[$];
	int fail_count = 0, num_checks = 0;
	event look;
	obr_src src (.clk_in(CLK_IN), .val_in(val), .data_out(DATA_IN));
	// Inverting build: the plain one is only a wire away
	obr_top #(.INVERT(1'b1)) dut (.*);
	initial forever #2.5 CLK_IN = ~CLK_IN;
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic final_report;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, e, input logic ee);
		int n;
		@(posedge CLK_IN);
		{PSEL_IN, PWRITE_IN, PADDR_IN, PWDATA_IN} <= {1'b1, w, a, d};
		@(posedge CLK_IN) PENABLE_IN <= 1;
		for (n = 0; n < 50; n++) begin
			@(posedge CLK_IN);
			if (PREADY_OUT === 1'b1) break;
		end
		if (n == 50) cmp(0, 1);
		if (n == 50) final_report();
		if (!w) cmp(PRDATA_OUT, e);
		cmp(PSLVERR_OUT, ee);
		{PSEL_IN, PENABLE_IN} <= 2'b00;
	endtask
	// Source adds a cycle, so three edges settle a capture
	task automatic step(input logic [7:0] v, input logic c, z, a, b, e);
		@(posedge CLK_IN);
		{val, CAPTURE_ENABLE_N_IN, ASYNC_ZERO_N_IN, DRIVE_ENABLE_A_N_IN} <= {v, c, z, a};
		{DRIVE_ENABLE_B_N_IN, DRIVE_ENABLE_C_N_IN} <= {b, e};
		if (!z) mw = '0;
		else if (!c) mw = ~v;
		exp_q.push_back({{8{!(a | b | e)}}, mw});
		repeat (3) @(posedge CLK_IN);
		#1 -> look;
	endtask
	always @(look) cmp({WORD_OE_OUT, WORD_OUT}, exp_q.pop_front());
	initial begin
		void'($urandom(32'hae25));
		repeat (20) @(posedge CLK_IN);
		RESETN_IN <= 1;
		apb(0, 12'h000, 0, 32'h1f, 0);
		apb(0, 12'h0f0, 0, 0, 1);
		apb(1, 12'h000, 32'h10, 0, 0);
		$display("register access done");
		for (int i = 0; i < 24; i++) step(8'($urandom), i[0], i % 7 != 3, i[1], i[2], i[3]);
		$display("pin sequence done");
		// Last step left capture off and driver A floated, so the word must still read back
		apb(0, 12'h008, 0, {24'h0, mw}, 0);
		apb(0, 12'h004, 0, 32'h1, 0);
		$display("readback done");
		@(posedge CLK_IN);
		final_report();
	end
endmodule // test_octet_bus_register_tristate
